// ==== common/drsel_pkg.sv ====
// Purpose: Constants and types for the run and step select block
// Assumes: Frequencies in 0.1 Hz units, byte addresses on the register bus
// Notes:   Function codes 0..24 fit five bits per terminal
package drsel_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int FW    = 16;
  localparam int NTERM = 5;
  localparam int FNW   = 5;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_FUNC   = 6'h04;
  localparam logic [5:0] OFF_KFREQ  = 6'h08;
  localparam logic [5:0] OFF_PRESET = 6'h0C;
  localparam logic [5:0] OFF_STATUS = 6'h28;

  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  typedef struct packed {
    logic       restart;
    logic       autostart;
    logic [1:0] inhibit;
    logic       kp_rev;
    logic [3:0] freq_mode;
    logic [1:0] run_src;
  } drsel_ctrl_t;

  typedef struct packed {
    logic         run;
    logic         rev;
  } drsel_cmd_t;

  localparam int          CTRL_W   = 11;
  localparam drsel_ctrl_t CTRL_RST = 11'h001;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] RS_KEYPAD = 2'h0;
  localparam logic [1:0] RS_TWO    = 2'h1;
  localparam logic [1:0] RS_RUNDIR = 2'h2;
  localparam logic [1:0] INH_FWD   = 2'h1;
  localparam logic [1:0] INH_REV   = 2'h2;
  localparam logic [4:0] FN_FWD    = 5'h00;
  localparam logic [4:0] FN_REV    = 5'h01;
  localparam logic [4:0] FN_STEP0  = 5'h05;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [24:0] FUNC_RST  = 25'h041_8820;
  localparam logic [FW-1:0] KFREQ_RST = 16'h0000;
  localparam logic [7:1][FW-1:0] PRESET_RST = {
    16'h0096, 16'h00C8, 16'h00FA, 16'h012C, 16'h012C, 16'h00C8, 16'h0064};
  localparam logic [2:0] POR_RST = 3'h7;

endpackage

// ==== logic/drsel_top.sv ====
// Purpose: Run command and step frequency selection of a motor drive
// Assumes: Avalon-MM slave, byte addresses, one wait cycle per access
// Notes:   Terminal and key pins pass two flip-flops before use
// Operation
// RL1 - Terminals coded 5, 6 and 7 form the step index, lowest code as bit 0.
// RL2 - Step index zero takes the keypad frequency command and frequency mode.
// RL3 - Step indices 1 to 3 pick presets defaulting to 10.0, 20.0 and 30.0 Hz.
// RL4 - Step indices 4 to 7 pick presets defaulting to 30.0, 25.0, 20.0, 15.0 Hz.
// RL5 - Run source 0 starts on the Run key and stops on the stop key.
// RL6 - In keypad mode the direction setting gives forward or reverse.
// RL7 - Run source 1 runs forward on the forward input, reverse on the reverse.
// RL8 - Run source 1 stops when both run inputs are equal.
// RL9 - Run source 2 runs on the forward input, reverse input picks direction.
// RL10 - Terminals with function 0 and 1 are the forward and reverse inputs.
// RL11 - Direction inhibit 0 allows both, 1 blocks forward, 2 blocks reverse.
// RL12 - Power-on start with run source 1 or 2 runs if the terminal is active.
// RL13 - Power-on start does nothing in keypad mode.
// RL14 - Restart after fault runs if the terminal is active when the fault clears.
// RL15 - Restart after fault does nothing in keypad mode.
// RL16 - Step index and run requests are re-evaluated every clock cycle.
// RL17 - A run request in a blocked direction is treated as a stop.
`timescale 1ns/1ps
module drsel_top
  import drsel_pkg::*;
(
  input  wire logic          CLOCK_I,
  input  wire logic          RST_N_I,
  input  wire logic [5:0]    ADDRESS_I,
  input  wire logic          READ_I,
  input  wire logic          WRITE_I,
  input  wire logic [31:0]   WRITEDATA_I,
  output logic      [31:0]   READDATA_O,
  output logic               WAITREQUEST_O,
  input  wire logic [4:0]    MULTI_INPUT_I,
  input  wire logic          KEY_RUN_I,
  input  wire logic          KEY_STOP_I,
  input  wire logic          FAULT_I,
  output logic               RUN_O,
  output logic               REVERSE_O,
  output logic [2:0]         STEP_INDEX_O,
  output logic               KEYPAD_FREQ_SEL_O,
  output logic [3:0]         FREQ_MODE_O,
  output logic [FW-1:0]      FREQ_REF_O
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [4:0] term_with(input logic [24:0] f, input logic [4:0] c);
    logic [4:0] m;
    m = '0;
    for (int i = 0; i < NTERM; i++)
      m[i] = (f[FNW*i +: FNW] == c);
    return m;
  endfunction

  function automatic logic [2:0] preset_idx(input logic [5:0] a);
    logic [2:0] k;
    k = '0;
    for (int i = 1; i < 8; i++)
      if (a == OFF_PRESET + 6'(4 * (i - 1)))
        k = 3'(i);
    return k;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  drsel_ctrl_t        ctrl_reg;
  logic [24:0]        func_reg;
  logic [FW-1:0]      kfreq_reg;
  logic [7:1][FW-1:0] preset_reg;
  logic [7:0]         s1_reg, s2_reg, s3_reg;
  logic               wait_reg;
  logic [31:0]        rdata_reg;
  logic               kp_run_reg, armed_reg;
  logic [2:0]         por_reg;
  drsel_cmd_t         cmd_reg;
  logic [2:0]         idx_reg;
  logic [FW-1:0]      freq_reg;
  logic               ksel_reg;
  logic [4:0]         term_s;
  logic               fault_s, fault_fall, run_edge, stop_edge, por;
  logic               fwd, rev, req_run, req_rev, kp_mode, want, dir_rev, blocked;
  logic               wr_ok;
  logic [2:0]         idx_next;
  drsel_cmd_t         cmd_next;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= {FAULT_I, KEY_STOP_I, KEY_RUN_I, MULTI_INPUT_I};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end

  assign term_s     = s2_reg[4:0];
  assign run_edge   = s2_reg[5] & ~s3_reg[5];
  assign stop_edge  = s2_reg[6] & ~s3_reg[6];
  assign fault_s    = s2_reg[7];
  assign fault_fall = s3_reg[7] & ~s2_reg[7];
  assign por        = por_reg[0];

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign wr_ok = WRITE_I & ~wait_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      wait_reg <= 1'b1;
    else
      wait_reg <= ~((READ_I | WRITE_I) & wait_reg);

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      rdata_reg <= '0;
    else if (READ_I & wait_reg)
    begin
      if (preset_idx(ADDRESS_I) != 3'h0)
        rdata_reg <= {16'h0000, preset_reg[preset_idx(ADDRESS_I)]};
      else
        case (ADDRESS_I)
          OFF_CTRL:   rdata_reg <= {21'h00_0000, ctrl_reg};
          OFF_FUNC:   rdata_reg <= {7'h00, func_reg};
          OFF_KFREQ:  rdata_reg <= {16'h0000, kfreq_reg};
          OFF_STATUS: rdata_reg <= {23'h00_0000, kp_run_reg, armed_reg, fault_s,
                                    ksel_reg, idx_reg, cmd_reg};
          default:    rdata_reg <= '0;
        endcase
    end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      ctrl_reg <= CTRL_RST;
    else if (wr_ok && ADDRESS_I == OFF_CTRL)
      ctrl_reg <= WRITEDATA_I[CTRL_W-1:0];

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      func_reg <= FUNC_RST;
    else if (wr_ok && ADDRESS_I == OFF_FUNC)
      func_reg <= WRITEDATA_I[24:0];

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      kfreq_reg <= KFREQ_RST;
    else if (wr_ok && ADDRESS_I == OFF_KFREQ)
      kfreq_reg <= WRITEDATA_I[FW-1:0];

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      preset_reg <= PRESET_RST; // RL3 RL4
    else if (wr_ok && preset_idx(ADDRESS_I) != 3'h0)
      preset_reg[preset_idx(ADDRESS_I)] <= WRITEDATA_I[FW-1:0];

  // ----------------------------------------
  // Step index and frequency
  // ----------------------------------------
  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_step
      assign idx_next[k] = |(term_with(func_reg, 5'(FN_STEP0 + k)) & term_s); // RL1
    end
  endgenerate

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      idx_reg  <= '0;
      freq_reg <= KFREQ_RST;
      ksel_reg <= 1'b1;
    end
    else
    begin
      idx_reg  <= idx_next; // RL16
      ksel_reg <= (idx_next == 3'h0); // RL2
      freq_reg <= (idx_next == 3'h0) ? kfreq_reg : preset_reg[idx_next]; // RL2 RL3 RL4
    end

  // ----------------------------------------
  // Run requests
  // ----------------------------------------
  assign fwd     = |(term_with(func_reg, FN_FWD) & term_s); // RL10
  assign rev     = |(term_with(func_reg, FN_REV) & term_s); // RL10
  assign kp_mode = (ctrl_reg.run_src == RS_KEYPAD);

  always_comb
  begin
    req_run = 1'b0;
    req_rev = 1'b0;
    case (ctrl_reg.run_src)
      RS_TWO:
      begin
        req_run = fwd ^ rev; // RL7 RL8
        req_rev = rev;
      end
      RS_RUNDIR:
      begin
        req_run = fwd; // RL9
        req_rev = rev;
      end
      default:
      begin
        req_run = 1'b0;
        req_rev = 1'b0;
      end
    endcase
  end

  assign dir_rev = kp_mode ? ctrl_reg.kp_rev : req_rev; // RL6
  assign want    = kp_mode ? kp_run_reg : (armed_reg & req_run);
  assign blocked = (dir_rev && ctrl_reg.inhibit == INH_REV) ||
                   (!dir_rev && ctrl_reg.inhibit == INH_FWD); // RL11
  assign cmd_next.run = want & ~fault_s & ~blocked; // RL17
  assign cmd_next.rev = dir_rev;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      kp_run_reg <= 1'b0;
    else if (!kp_mode || fault_s || stop_edge)
      kp_run_reg <= 1'b0; // RL5
    else if (run_edge)
      kp_run_reg <= 1'b1; // RL5

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      por_reg <= POR_RST;
    else
      por_reg <= {1'b0, por_reg[2:1]};

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      armed_reg <= 1'b0;
    else if (por)
      armed_reg <= ctrl_reg.autostart & ~kp_mode; // RL12 RL13
    else if (fault_s)
      armed_reg <= 1'b0;
    else if (fault_fall)
      armed_reg <= ctrl_reg.restart & ~kp_mode; // RL14 RL15
    else if (!req_run)
      armed_reg <= 1'b1;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
      cmd_reg <= '0;
    else
      cmd_reg <= cmd_next; // RL16

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign READDATA_O        = rdata_reg;
  assign WAITREQUEST_O     = wait_reg;
  assign RUN_O             = cmd_reg.run;
  assign REVERSE_O         = cmd_reg.rev;
  assign STEP_INDEX_O      = idx_reg;
  assign KEYPAD_FREQ_SEL_O = ksel_reg;
  assign FREQ_MODE_O       = ctrl_reg.freq_mode;
  assign FREQ_REF_O        = freq_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  property p_step;
    ($stable(func_reg) && func_reg[24:10] == {5'(FN_STEP0 + 2), 5'(FN_STEP0 + 1), FN_STEP0})
      |-> idx_reg == $past(term_s[4:2]);
  endproperty
  a_step: assert property (p_step) else $error("step index not taken"); // RL1

  property p_base;
    (idx_reg == 3'h0) |-> (freq_reg == $past(kfreq_reg)) && ksel_reg;
  endproperty
  a_base: assert property (p_base) else $error("base frequency wrong"); // RL2

  property p_preset;
    (idx_reg != 3'h0 && $stable(preset_reg)) |-> freq_reg == preset_reg[idx_reg];
  endproperty
  a_preset: assert property (p_preset) else $error("preset frequency wrong"); // RL3

  property p_kprun;
    (kp_mode && run_edge && !stop_edge && !fault_s) |=> kp_run_reg;
  endproperty
  a_kprun: assert property (p_kprun) else $error("keypad run lost"); // RL5

  property p_kpdir;
    kp_mode |=> (cmd_reg.rev == $past(ctrl_reg.kp_rev));
  endproperty
  a_kpdir: assert property (p_kpdir) else $error("keypad direction wrong"); // RL6

  property p_two;
    (ctrl_reg.run_src == RS_TWO && fwd == rev) |=> !cmd_reg.run;
  endproperty
  a_two: assert property (p_two) else $error("equal inputs did not stop"); // RL8

  property p_inh;
    ($stable(ctrl_reg) && ctrl_reg.inhibit == INH_FWD) |-> !(cmd_reg.run && !cmd_reg.rev);
  endproperty
  a_inh: assert property (p_inh) else $error("blocked forward ran"); // RL17

  property p_por;
    (por && (!ctrl_reg.autostart || kp_mode)) |=> !armed_reg;
  endproperty
  a_por: assert property (p_por) else $error("power-on start misfired"); // RL13

  property p_restart;
    (!por && fault_fall && ctrl_reg.restart && !kp_mode) |=> armed_reg;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing"); // RL14

  property p_norestart;
    (!por && fault_fall && (!ctrl_reg.restart || kp_mode)) |=> !armed_reg;
  endproperty
  a_norestart: assert property (p_norestart) else $error("restart misfired"); // RL15

endmodule

// ==== sim/drsel_panel.sv ====
// Purpose: Terminal, keypad and fault model at the drive's far side
// Assumes: Levels change just after the rising clock edge
// Notes:   Pins hold their level until the bench commands a change
`timescale 1ns/1ps
module drsel_panel
  import drsel_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [4:0] term_i,
  input  wire logic       run_i,
  input  wire logic       stop_i,
  input  wire logic       fault_i,
  output logic      [4:0] term_o,
  output logic            run_o,
  output logic            stop_o,
  output logic            fault_o
);
  initial
  begin
    term_o  = 5'h00;
    run_o   = 1'h0;
    stop_o  = 1'h0;
    fault_o = 1'h0;
  end
  always @(posedge clk_i)
  begin
    term_o  <= term_i;
    run_o   <= run_i;
    stop_o  <= stop_i;
    fault_o <= fault_i;
  end
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the run and step select block
// Assumes: One wait cycle per bus access, outputs settle within six edges
// Notes:   Reset values first, then table rows, keypad, fault and power-on cases
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module tb_top
  import drsel_pkg::*;
;
  typedef struct packed {
    logic [10:0] ctrl;
    logic [4:0]  pins;
    logic        run;
    logic        rev;
    logic [2:0]  idx;
    logic [15:0] fref;
  } drsel_row_t;
  localparam drsel_row_t ROWS [13] = '{
    '{11'h00D, 5'h01, 1'h1, 1'h0, 3'h0, 16'h0032},
    '{11'h001, 5'h06, 1'h1, 1'h1, 3'h1, 16'h0064},
    '{11'h001, 5'h0B, 1'h0, 1'h0, 3'h2, 16'h00C8},
    '{11'h001, 5'h0C, 1'h0, 1'h0, 3'h3, 16'h012C},
    '{11'h081, 5'h11, 1'h0, 1'h0, 3'h4, 16'h012C},
    '{11'h081, 5'h16, 1'h1, 1'h1, 3'h5, 16'h00FA},
    '{11'h101, 5'h1A, 1'h0, 1'h0, 3'h6, 16'h00C8},
    '{11'h101, 5'h1D, 1'h1, 1'h0, 3'h7, 16'h0096},
    '{11'h002, 5'h01, 1'h1, 1'h0, 3'h0, 16'h0032},
    '{11'h002, 5'h03, 1'h1, 1'h1, 3'h0, 16'h0032},
    '{11'h002, 5'h02, 1'h0, 1'h0, 3'h0, 16'h0032},
    '{11'h102, 5'h03, 1'h0, 1'h0, 3'h0, 16'h0032},
    '{11'h003, 5'h01, 1'h0, 1'h0, 3'h0, 16'h0032}};
  localparam logic [11:0] FCFG [3] = '{12'hC01, 12'h001, 12'h400};
  logic        clk, rst_n, rd, wr, waitreq, krun, kstop, fault;
  logic        run, rev, kfs, t_run, t_stop, t_fault;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [4:0]  mi, t_term;
  logic [2:0]  idx;
  logic [3:0]  fmode;
  logic [15:0] fref;
  int          error_cnt, comparisons;
  drsel_top drsel_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(addr), .READ_I(rd),
    .WRITE_I(wr), .WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(waitreq),
    .MULTI_INPUT_I(mi), .KEY_RUN_I(krun), .KEY_STOP_I(kstop), .FAULT_I(fault),
    .RUN_O(run), .REVERSE_O(rev), .STEP_INDEX_O(idx), .KEYPAD_FREQ_SEL_O(kfs),
    .FREQ_MODE_O(fmode), .FREQ_REF_O(fref));
  drsel_panel drsel_panel_inst (.clk_i(clk), .term_i(t_term), .run_i(t_run),
    .stop_i(t_stop), .fault_i(t_fault), .term_o(mi), .run_o(krun), .stop_o(kstop),
    .fault_o(fault));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'h0 && n < 100);
    if (waitreq !== 1'h0)
    begin
      error_cnt++;
      summarize();
    end
    r = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic key(input logic s);
    if (s)
      t_stop <= 1'h1;
    else
      t_run <= 1'h1;
    settle();
    t_run <= 1'h0;
    t_stop <= 1'h0;
    settle();
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    {rst_n, rd, wr, t_run, t_stop, t_fault} = 6'h00;
    addr = 6'h00;
    wdata = 32'h0000_0000;
    t_term = 5'h00;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    `CHK({run, kfs, fref}, 18'h1_0000)
    bus(1'h0, OFF_CTRL, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0001)
    bus(1'h0, OFF_FUNC, 32'h0000_0000, q);
    `CHK(q, 32'h0041_8820)
    bus(1'h0, OFF_PRESET, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0064)
    bus(1'h0, 6'h24, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0096)
    bus(1'h0, 6'h2C, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    bus(1'h1, OFF_FUNC, 32'h0073_1420, q);
    bus(1'h1, OFF_KFREQ, 32'h0000_0032, q);
    foreach (ROWS[i])
    begin
      bus(1'h1, OFF_CTRL, {21'h0, ROWS[i].ctrl}, q);
      t_term <= ROWS[i].pins;
      settle();
      `CHK({run, idx, fref}, {ROWS[i].run, ROWS[i].idx, ROWS[i].fref})
      `CHK({kfs, fmode}, {ROWS[i].idx == 3'h0, ROWS[i].ctrl[5:2]})
      if (ROWS[i].run)
        `CHK(rev, ROWS[i].rev)
    end
    bus(1'h1, OFF_CTRL, 32'h0000_0000, q);
    t_term <= 5'h01;
    settle();
    `CHK(run, 1'h0)
    key(1'h0);
    `CHK({run, rev}, 2'h2)
    bus(1'h1, OFF_CTRL, 32'h0000_0040, q);
    settle();
    `CHK({run, rev}, 2'h3)
    key(1'h1);
    `CHK(run, 1'h0)
    bus(1'h1, OFF_CTRL, 32'h0000_0140, q);
    key(1'h0);
    `CHK(run, 1'h0)
    foreach (FCFG[i])
    begin
      bus(1'h1, OFF_CTRL, {21'h0, FCFG[i][10:0]}, q);
      if (i == 2)
        key(1'h0);
      t_fault <= 1'h1;
      settle();
      `CHK(run, 1'h0)
      t_fault <= 1'h0;
      settle();
      `CHK(run, FCFG[i][11])
    end
    for (int j = 0; j < 3; j++)
    begin
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      if (j != 0)
        bus(1'h1, OFF_CTRL, (j == 1) ? 32'h0000_0201 : 32'h0000_0200, q);
      settle();
      `CHK(run, j == 1)
    end
    summarize();
  end
endmodule
